// ==== verilog/dcs_pkg.sv ====
// shared types and constants of the serial port clock source selector
package dcs_pkg;

   // -----------------------------------------------------------------
   // clock rates
   // -----------------------------------------------------------------
   localparam int CLK_SYS_HZ      = 100_000_000;
   localparam int OSC_FREQ_HZ     = 1_000_000;
   localparam int OSC_HALF_CYCLES = CLK_SYS_HZ / (2 * OSC_FREQ_HZ);
   localparam int OSC_CNT_W       = 16;

   // -----------------------------------------------------------------
   // transmit clock source setting
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      TXS_IFACE = 2'b00,
      TXS_INT   = 2'b01,
      TXS_EXT   = 2'b10
   } dcs_txsrc_t;

   // -----------------------------------------------------------------
   // index of a clock level inside the switch source vector
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_RC  = 2'b00,
      SRC_INT = 2'b01,
      SRC_EXT = 2'b10,
      SRC_FAR = 2'b11
   } dcs_src_t;

   // -----------------------------------------------------------------
   // switch states
   // -----------------------------------------------------------------
   typedef enum logic {
      SW_RUN  = 1'b0,
      SW_WAIT = 1'b1
   } dcs_sw_state_t;

   localparam dcs_src_t SRC_RESET = SRC_INT;

endpackage

// ==== verilog/dcs_clk_switch.sv ====
// glitch-free selector of one clock level out of four sampled sources
module dcs_clk_switch
   import dcs_pkg::*;
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // sources and selection
   input  wire logic [3:0] src_lvl,
   input  wire dcs_src_t   sel,
   // selected clock level and lock status
   output logic            clk_out,
   output logic            locked
);

   typedef struct packed {
      dcs_sw_state_t st;
      dcs_src_t      cur;
      logic          out;
   } dcs_sw_t;

   dcs_sw_t s_reg;
   dcs_sw_t s_next;

   // ------------------------------------------------------------------
   // switch: let the old clock finish its high phase, park low, then
   // hand over only while the new one is low as well
   // ------------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      case (s_reg.st)
         SW_RUN: begin
            s_next.out = src_lvl[s_reg.cur];
            if (sel != s_reg.cur) begin
               s_next.st = SW_WAIT;
            end
         end
         SW_WAIT: begin
            s_next.out = s_reg.out & src_lvl[s_reg.cur];
            if (!s_reg.out && !src_lvl[sel]) begin
               s_next.cur = sel;
               s_next.st  = SW_RUN;
            end
         end
         default: begin
            s_next.st = SW_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg <= '{st: SW_RUN, cur: SRC_RESET, out: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign clk_out = s_reg.out;
   assign locked  = (s_reg.st == SW_RUN) && (s_reg.cur == sel);

endmodule

// ==== verilog/dcs_clock_select.sv ====
// transmit and receive clock source selection of the synchronous port
module dcs_clock_select
   import dcs_pkg::*;
#(
   parameter int OSC_HALF = OSC_HALF_CYCLES
)
(
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // settings, taken while the port is idle
   input  wire logic       cfg_dce_mode,
   input  wire logic       cfg_x21_mode,
   input  wire logic [1:0] cfg_tx_src,
   input  wire logic       cfg_rx_far,
   input  wire logic       port_idle,
   // clock pins
   input  wire logic       tc_i,
   output logic            tc_o,
   output logic            tc_oe,
   input  wire logic       rc_i,
   output logic            rc_o,
   output logic            rc_oe,
   input  wire logic       xtc_i,
   output logic            xtc_o,
   output logic            xtc_oe,
   input  wire logic       station_clock_input,
   // data pins
   input  wire logic       rx_data_pin,
   output logic            tx_data_pin,
   // user side
   input  wire logic       tx_bit,
   output logic            tx_bit_ready,
   output logic            rx_bit,
   output logic            rx_bit_valid
);

   typedef struct packed {
      logic [1:0]           tc_sy;
      logic [1:0]           rc_sy;
      logic [1:0]           xtc_sy;
      logic [1:0]           stn_sy;
      logic [1:0]           rd_sy;
      logic [OSC_CNT_W-1:0] osc_cnt;
      logic                 osc_lvl;
      logic                 dce;
      logic                 x21;
      dcs_txsrc_t           txs;
      logic                 rx_far;
      logic                 rx_prev;
      logic                 tx_prev;
      logic                 rx_bit;
      logic                 rx_valid;
      logic                 td;
   } dcs_st_t;

   localparam dcs_st_t ST_RESET = '{
      txs: TXS_INT, default: '0
   };
   localparam logic [OSC_CNT_W-1:0] OSC_LAST =
      OSC_CNT_W'(OSC_HALF - 1);

   dcs_st_t    s_reg;
   dcs_st_t    s_next;
   logic [3:0] src_lvl;
   dcs_src_t   tx_sel;
   dcs_src_t   rx_sel;
   logic       tx_clk;
   logic       rx_clk;
   logic       tx_locked;
   logic       rx_locked;
   logic       tx_fall;
   logic       rx_rise;

   // ------------------------------------------------------------------
   // source decode
   // ------------------------------------------------------------------
   function automatic dcs_src_t tx_source(input logic       x21,
                                          input dcs_txsrc_t txs);
      dcs_src_t r;
      r = SRC_INT;
      if (x21) begin
         r = SRC_FAR;
      end else begin
         case (txs)
            TXS_IFACE: r = SRC_FAR;
            TXS_INT:   r = SRC_INT;
            TXS_EXT:   r = SRC_EXT;
            default:   r = SRC_INT;
         endcase
      end
      return r;
   endfunction

   function automatic dcs_src_t rx_source(input logic       dce,
                                          input logic       x21,
                                          input dcs_txsrc_t txs,
                                          input logic       far);
      dcs_src_t r;
      r = tx_source(x21, txs);
      if (x21) begin
         r = SRC_FAR;
      end else if (dce) begin
         if (far) begin
            r = SRC_FAR;
         end
      end else if (txs == TXS_IFACE || far) begin
         r = SRC_RC;
      end
      return r;
   endfunction

   // far clock slot: TC as terminal, XTC as data set
   assign src_lvl = {s_reg.dce ? s_reg.xtc_sy[1] : s_reg.tc_sy[1],
                     s_reg.stn_sy[1], s_reg.osc_lvl, s_reg.rc_sy[1]};
   assign tx_sel  = tx_source(s_reg.x21, s_reg.txs);
   assign rx_sel  = rx_source(s_reg.dce, s_reg.x21, s_reg.txs,
                              s_reg.rx_far);

   dcs_clk_switch u_tx_switch (
      .clk_sys (clk_sys),
      .rst     (rst),
      .src_lvl (src_lvl),
      .sel     (tx_sel),
      .clk_out (tx_clk),
      .locked  (tx_locked)
   );

   dcs_clk_switch u_rx_switch (
      .clk_sys (clk_sys),
      .rst     (rst),
      .src_lvl (src_lvl),
      .sel     (rx_sel),
      .clk_out (rx_clk),
      .locked  (rx_locked)
   );

   assign tx_fall = s_reg.tx_prev & ~tx_clk;
   assign rx_rise = ~s_reg.rx_prev & rx_clk;

   // ------------------------------------------------------------------
   // state update
   // ------------------------------------------------------------------
   always_comb begin
      s_next        = s_reg;
      s_next.tc_sy  = {s_reg.tc_sy[0], tc_i};
      s_next.rc_sy  = {s_reg.rc_sy[0], rc_i};
      s_next.xtc_sy = {s_reg.xtc_sy[0], xtc_i};
      s_next.stn_sy = {s_reg.stn_sy[0], station_clock_input};
      s_next.rd_sy  = {s_reg.rd_sy[0], rx_data_pin};
      // internal oscillator made from the system clock
      if (s_reg.osc_cnt >= OSC_LAST) begin
         s_next.osc_cnt = '0;
         s_next.osc_lvl = ~s_reg.osc_lvl;
      end else begin
         s_next.osc_cnt = s_reg.osc_cnt + OSC_CNT_W'(1);
      end
      // settings taken only while idle so no frame sees a switch
      if (port_idle) begin
         s_next.dce    = cfg_dce_mode;
         s_next.x21    = cfg_x21_mode;
         s_next.txs    = dcs_txsrc_t'(cfg_tx_src);
         s_next.rx_far = cfg_rx_far;
      end
      s_next.rx_prev  = rx_clk;
      s_next.tx_prev  = tx_clk;
      s_next.rx_valid = rx_rise;
      if (rx_rise) begin
         s_next.rx_bit = s_reg.rd_sy[1];
      end
      // launch on the falling edge so the far end samples on the rise
      if (tx_fall) begin
         s_next.td = tx_bit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg <= ST_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------------
   // pins
   // ------------------------------------------------------------------
   assign xtc_o        = tx_clk;
   assign xtc_oe       = ~s_reg.dce & ~s_reg.x21;
   assign tc_o         = tx_clk;
   assign tc_oe        = s_reg.dce;
   assign rc_o         = tx_clk;
   assign rc_oe        = s_reg.dce & ~s_reg.x21;
   assign tx_data_pin  = s_reg.td;
   assign tx_bit_ready = tx_fall;
   assign rx_bit       = s_reg.rx_bit;
   assign rx_bit_valid = s_reg.rx_valid;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence tx_steady;
      tx_locked && $stable(tx_sel);
   endsequence

   sequence rx_edge;
      !rx_clk ##1 rx_clk;
   endsequence

   chk_rx_sample: assert property (
      rx_edge |=> rx_bit_valid && rx_bit == $past(s_reg.rd_sy[1]))
      else $error("rx bit not taken on receive clock rise");

   chk_xtc_drive: assert property (
      !s_reg.dce && !s_reg.x21 |-> xtc_oe && !tc_oe && !rc_oe)
      else $error("xtc not driven as terminal");

   chk_iface_follow: assert property (
      tx_steady ##0 (s_reg.txs == TXS_IFACE && !s_reg.dce && !s_reg.x21)
      |=> xtc_o == $past(s_reg.tc_sy[1]))
      else $error("xtc does not follow tc");

   chk_tx_launch: assert property (
      tx_fall |=> tx_data_pin == $past(tx_bit) && !tx_bit_ready)
      else $error("tx data not launched on clock fall");

   chk_rx_rc_sel: assert property (
      !s_reg.dce && !s_reg.x21 && (s_reg.txs == TXS_IFACE || s_reg.rx_far)
      |-> rx_sel == SRC_RC)
      else $error("receive clock not rc");

   chk_int_rx_sel: assert property (
      !s_reg.x21 && !s_reg.rx_far && s_reg.txs == TXS_INT
      |-> rx_sel == SRC_INT && tx_sel == SRC_INT)
      else $error("internal receive clock not selected");

   chk_ext_rx_sel: assert property (
      !s_reg.x21 && !s_reg.rx_far && s_reg.txs == TXS_EXT
      |-> rx_sel == SRC_EXT && tx_sel == SRC_EXT)
      else $error("station clock not selected");

   chk_x21_single: assert property (
      s_reg.x21 |-> rx_sel == SRC_FAR && tx_sel == SRC_FAR && !xtc_oe)
      else $error("single clock mode split the clocks");

   chk_dce_drive: assert property (
      s_reg.dce |-> tc_oe && tc_o == tx_clk && !xtc_oe
      && rc_oe == !s_reg.x21
      && (s_reg.x21 || rx_sel == (s_reg.rx_far ? SRC_FAR : tx_sel)))
      else $error("data set clocks not driven");

   chk_cfg_idle: assert property (
      !port_idle |=> $stable(s_reg.txs) && $stable(s_reg.dce)
                     && $stable(s_reg.rx_far) && $stable(s_reg.x21))
      else $error("selection changed while busy");

   chk_no_runt: assert property (
      $rose(tx_clk) |=> tx_clk)
      else $error("runt pulse on transmit clock");

endmodule

// ==== tb/dcs_dce_model.sv ====
// data set model: free-running transmit and receive clocks and receive data
module dcs_dce_model #(
   parameter int TC_HALF = 6,
   parameter int RC_HALF = 10
)
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // terminal side of the link
   input  wire logic xtc,
   input  wire logic td,
   // data set side of the link
   output logic      tc,
   output logic      rc,
   output logic      rd
);
   timeunit 1ns;
   timeprecision 1ps;

   int   tc_cnt;
   int   rc_cnt;
   logic xtc_d;
   logic td_seen;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tc_cnt  <= 0;
         rc_cnt  <= 0;
         tc      <= 1'b0;
         rc      <= 1'b0;
         rd      <= 1'b0;
         xtc_d   <= 1'b0;
         td_seen <= 1'b0;
      end else begin
         tc_cnt <= (tc_cnt == TC_HALF - 1) ? 0 : tc_cnt + 1;
         rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
         if (tc_cnt == TC_HALF - 1) tc <= ~tc;
         if (rc_cnt == RC_HALF - 1) begin
            rc <= ~rc;
            // new data launched on the falling receive clock
            if (rc) rd <= ~rd;
         end
         xtc_d <= xtc;
         // transmit data taken on the terminal clock where offered
         if (xtc && !xtc_d) td_seen <= td;
      end
   end
endmodule

// ==== tb/dcs_clock_select_tb_top.sv ====
// self-checking bench of the clock source selector
module dcs_clock_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dcs_pkg::*;

   logic       clk_sys, rst, dce, x21, far, idle, stn, term, tx_bit;
   logic [1:0] src;
   logic       tc_i, tc_o, tc_oe, rc_i, rc_o, rc_oe, xtc_o, xtc_oe;
   logic       rd, td, tx_rdy, rx_bit, rx_vld, m_tc, m_rc, b, pend;
   int         error_cnt, checked, sc, tcn, rx_miss;

   // pins resolved from the selector's output enables, the model drives otherwise
   assign tc_i = tc_oe ? tc_o : m_tc;
   assign rc_i = rc_oe ? rc_o : m_rc;

   dcs_clock_select #(.OSC_HALF(3)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .cfg_dce_mode(dce),
      .cfg_x21_mode(x21), .cfg_tx_src(src), .cfg_rx_far(far),
      .port_idle(idle), .tc_i(tc_i), .tc_o(tc_o), .tc_oe(tc_oe),
      .rc_i(rc_i), .rc_o(rc_o), .rc_oe(rc_oe),
      .xtc_i(xtc_oe ? xtc_o : term), .xtc_o(xtc_o), .xtc_oe(xtc_oe),
      .station_clock_input(stn), .rx_data_pin(rd), .tx_data_pin(td),
      .tx_bit(tx_bit), .tx_bit_ready(tx_rdy), .rx_bit(rx_bit),
      .rx_bit_valid(rx_vld));

   dcs_dce_model #(.TC_HALF(6), .RC_HALF(10)) dce_u (
      .clk_sys(clk_sys), .rst(rst), .xtc(xtc_oe ? xtc_o : term),
      .td(td), .tc(m_tc), .rc(m_rc), .rd(rd));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // station clock half 5, far terminal clock half 7, data every 5 cycles
   always @(posedge clk_sys) begin
      sc <= (sc == 4) ? 0 : sc + 1;
      tcn <= (tcn == 6) ? 0 : tcn + 1;
      if (sc == 4) stn <= ~stn;
      if (tcn == 6) term <= ~term;
      if (sc == 2) tx_bit <= ~tx_bit;
   end

   task automatic chk(input string nm, input int e, input int g);
      checked++;
      if (g < e - 1 || g > e + 1) begin
         error_cnt++;
         $display("FAIL %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic chkb(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %b seen %b", nm, e, g);
      end
   endtask

   // transmit data follows the bit offered while ready was high
   always @(negedge clk_sys) begin
      if (!rst && pend) chkb("tx_data_pin", b, td);
      // on rc the data line is steady around the rise, so rx_bit must match
      if (!rst && rx_vld === 1'b1 && rx_bit !== rd) rx_miss++;
      pend = (tx_rdy === 1'b1) && !rst;
      b = tx_bit;
   end

   task automatic setcfg(input logic d, input logic x, input logic [1:0] s,
                         input logic f, input logic take);
      @(posedge clk_sys);
      dce <= d;
      x21 <= x;
      src <= s;
      far <= f;
      idle <= take;
      repeat (40) @(posedge clk_sys);
      idle <= 1'b0;
      repeat (40) @(posedge clk_sys);
   endtask

   // rises of xtc_o, tc_o and count of receive strobes over 240 cycles
   task automatic measure(output int xr, output int tr, output int vr);
      logic px, pt;
      xr = 0;
      tr = 0;
      vr = 0;
      rx_miss = 0;
      px = xtc_o;
      pt = tc_o;
      repeat (240) begin
         @(negedge clk_sys);
         if (xtc_o === 1'b1 && px === 1'b0) xr++;
         if (tc_o === 1'b1 && pt === 1'b0) tr++;
         if (rx_vld === 1'b1) vr++;
         px = xtc_o;
         pt = tc_o;
      end
   endtask

   task automatic run_terminal();
      int xr, tr, vr;
      setcfg(1'b0, 1'b0, 2'b00, 1'b0, 1'b1);
      measure(xr, tr, vr);
      chkb("xtc_oe", 1'b1, xtc_oe);
      chk("xtc from tc", 20, xr);
      chk("rx on rc", 12, vr);
      chkb("rx_bit on rc", 1'b1, rx_miss == 0);
      setcfg(1'b0, 1'b0, 2'b01, 1'b0, 1'b1);
      measure(xr, tr, vr);
      chk("xtc from osc", 40, xr);
      chk("rx on osc", 40, vr);
      setcfg(1'b0, 1'b0, 2'b01, 1'b1, 1'b1);
      measure(xr, tr, vr);
      chk("rx on rc int", 12, vr);
      chkb("rx_bit on rc int", 1'b1, rx_miss == 0);
      setcfg(1'b0, 1'b0, 2'b10, 1'b0, 1'b1);
      measure(xr, tr, vr);
      chk("xtc from station", 24, xr);
      chk("rx on station", 24, vr);
      setcfg(1'b0, 1'b0, 2'b10, 1'b1, 1'b1);
      measure(xr, tr, vr);
      chk("rx on rc ext", 12, vr);
      chkb("rx_bit on rc ext", 1'b1, rx_miss == 0);
      setcfg(1'b0, 1'b0, 2'b01, 1'b0, 1'b0);
      measure(xr, tr, vr);
      chk("change while busy", 24, xr);
      chk("rx kept while busy", 12, vr);
      // the unused source code falls back to the internal oscillator
      setcfg(1'b0, 1'b0, 2'b11, 1'b0, 1'b1);
      measure(xr, tr, vr);
      chk("xtc from code 3", 40, xr);
   endtask

   task automatic run_x21_dce();
      int xr, tr, vr;
      setcfg(1'b0, 1'b1, 2'b01, 1'b0, 1'b1);
      measure(xr, tr, vr);
      chkb("xtc_oe x21", 1'b0, xtc_oe);
      chk("x21 rx on tc", 20, vr);
      setcfg(1'b1, 1'b0, 2'b01, 1'b0, 1'b1);
      measure(xr, tr, vr);
      chkb("tc_oe", 1'b1, tc_oe);
      chkb("rc_oe", 1'b1, rc_oe);
      chk("tc from osc", 40, tr);
      chk("dce rx on osc", 40, vr);
      setcfg(1'b1, 1'b0, 2'b01, 1'b1, 1'b1);
      measure(xr, tr, vr);
      chk("dce rx on xtc", 17, vr);
      setcfg(1'b1, 1'b0, 2'b00, 1'b0, 1'b1);
      measure(xr, tr, vr);
      chk("tc from xtc", 17, tr);
      chk("dce iface rx on xtc", 17, vr);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      {rst, dce, x21, far, idle, stn, term, tx_bit, pend, b} = 10'h201;
      src = 2'b00;
      sc = 0;
      tcn = 0;
      rx_miss = 0;
      error_cnt = 0;
      checked = 0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      chkb("xtc_oe reset", 1'b1, xtc_oe);
      chkb("tc_oe reset", 1'b0, tc_oe);
      chkb("rc_oe reset", 1'b0, rc_oe);
      run_terminal();
      run_x21_dce();
      tally_and_finish();
   end

   // whole run needs about 3600 cycles
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end
endmodule
